// ==== common/apm_pkg.sv ====
`default_nettype none
package apm_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned T_IDLE_MS = 70;
  localparam int unsigned T_PU_FULL_US = 300;
  localparam int unsigned T_PU_PART_US = 50;
  localparam int unsigned T_CALTO_MS = 32;
  localparam int unsigned IDLE_CYC_DEF =
    (T_IDLE_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PU_FULL_CYC_DEF =
    (T_PU_FULL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PU_PART_CYC_DEF =
    (T_PU_PART_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CALTO_CYC_DEF =
    (T_CALTO_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CAL_CYC_DEF = CALTO_CYC_DEF;
  localparam int unsigned CONV_CYC_DEF = 16;
  // ==========================================================
  // Control word layout
  localparam int unsigned WD_W = 12;
  localparam int unsigned WD_TGT_HI = 11;
  localparam int unsigned WD_TGT_LO = 10;
  localparam int unsigned WD_PSEL_HI = 9;
  localparam int unsigned WD_PSEL_LO = 8;
  localparam int unsigned WD_START = 0;
  // ==========================================================
  // Host register map
  localparam logic [7:0] ADDR_WDATA = 8'h00;
  localparam logic [7:0] ADDR_TRIG = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int unsigned CTRL_SLEEP_N = 0;
  localparam int unsigned CTRL_EXT_REF = 1;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_FULL_AFTER = 2'b01,
    PM_FULL_NOW = 2'b10,
    PM_PART_AFTER = 2'b11
  } apm_mode_t;
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_TMO = 3'b001,
    ST_WAIT_CAL = 3'b010,
    ST_CAL = 3'b011,
    ST_IDLE = 3'b100,
    ST_CONV = 3'b101,
    ST_PD_FULL = 3'b110,
    ST_PD_PART = 3'b111
  } apm_state_t;
endpackage : apm_pkg
`default_nettype wire

// ==== common/apm_link_if.sv ====
`default_nettype none
interface apm_link_if import apm_pkg::*;;
  logic wr_stb;
  logic [WD_W-1:0] wr_data;
  logic trig_n;
  logic sleep_n;
  logic busy;
  modport dev (input wr_stb, input wr_data, input trig_n, input sleep_n, output busy);
  modport host (output wr_stb, output wr_data, output trig_n, output sleep_n, input busy);
endinterface : apm_link_if
`default_nettype wire

// ==== hw/apm_sync3.sv ====
`default_nettype none
module apm_sync3 #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic d_i, // Async input
  output logic lvl_o, // Filtered level
  output logic fall_o, // Falling pulse
  output logic rise_o // Rising pulse
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Level accepted once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_o <= INIT;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      if (s2_reg == s3_reg) begin
        lvl_o <= s3_reg;
      end
      fall_o <= (s2_reg == s3_reg) && lvl_o && !s3_reg;
      rise_o <= (s2_reg == s3_reg) && !lvl_o && s3_reg;
    end
  end
endmodule : apm_sync3
`default_nettype wire

// ==== hw/apm_dev_end.sv ====
// Added by the designer: the device end that decodes control words and sequences the power states.
`default_nettype none
module apm_dev_end import apm_pkg::*; #(
  parameter int unsigned CALTO_CYC = CALTO_CYC_DEF,
  parameter int unsigned CAL_CYC = CAL_CYC_DEF,
  parameter int unsigned CONV_CYC = CONV_CYC_DEF
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  apm_link_if.dev link, // Link to host
  output logic ref_on_o, // Reference powered
  output logic core_on_o, // Converter core powered
  output logic conv_done_o, // Conversion finished pulse
  output logic cal_done_o, // Calibration finished pulse
  output logic [1:0] mode_o // Power select bits
);
  if (CALTO_CYC < 1 || CAL_CYC < 1 || CONV_CYC < 1) begin : g_chk
    $error("apm_dev_end: cycle counts must be at least one");
  end

  apm_state_t st_reg;
  apm_state_t st_next;
  apm_mode_t mode_reg;
  apm_mode_t mode_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic skip_reg;
  logic skip_next;
  logic busy_reg;
  logic done_next;
  logic cal_next;
  logic wr_real;
  logic start_bit;
  logic trig_fall;
  logic trig_rise;
  logic sleep_lvl;
  logic wake_ok;
  logic cnt_to_end;
  logic cnt_cal_end;
  logic cnt_conv_end;

  // ==========================================================
  // Pin synchronisers
  apm_sync3 #(.INIT(1'b1)) u_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(link.trig_n),
    .lvl_o(),
    .fall_o(trig_fall),
    .rise_o(trig_rise)
  );
  apm_sync3 #(.INIT(1'b1)) u_sleep (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(link.sleep_n),
    .lvl_o(sleep_lvl),
    .fall_o(),
    .rise_o()
  );

  // ==========================================================
  // Control word decode
  // Dummy write discarded
  assign wr_real = link.wr_stb && (link.wr_data[WD_TGT_HI:WD_TGT_LO] != 2'b00);
  assign start_bit = wr_real && link.wr_data[WD_START];
  assign mode_next = wr_real ? apm_mode_t'(link.wr_data[WD_PSEL_HI:WD_PSEL_LO]) : mode_reg;
  assign wake_ok = trig_fall && sleep_lvl &&
                   (mode_reg == PM_FULL_AFTER || mode_reg == PM_PART_AFTER);
  assign cnt_to_end = (cnt_reg == 32'(CALTO_CYC - 1));
  assign cnt_cal_end = (cnt_reg == 32'(CAL_CYC - 1));
  assign cnt_conv_end = (cnt_reg == 32'(CONV_CYC - 1));

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg + 32'h0000_0001;
    skip_next = skip_reg;
    done_next = 1'b0;
    cal_next = 1'b0;
    case (st_reg)
      ST_INIT: begin
        cnt_next = 32'h0000_0000;
        if (trig_fall) begin
          st_next = ST_TMO;
        end
      end
      ST_TMO: begin
        if (wr_real) begin
          skip_next = 1'b1;
        end
        if (cnt_to_end) begin
          cnt_next = 32'h0000_0000;
          st_next = (skip_reg || wr_real) ? ST_IDLE : ST_WAIT_CAL;
        end
      end
      ST_WAIT_CAL: begin
        cnt_next = 32'h0000_0000;
        if (wr_real) begin
          st_next = ST_IDLE;
        end else if (trig_fall) begin
          st_next = ST_CAL;
        end
      end
      ST_CAL: begin
        if (cnt_cal_end) begin
          cnt_next = 32'h0000_0000;
          cal_next = 1'b1;
          st_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        cnt_next = 32'h0000_0000;
        if (mode_next == PM_FULL_NOW || !sleep_lvl) begin
          st_next = ST_PD_FULL;
        end else if (trig_rise || start_bit) begin
          st_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (mode_next == PM_FULL_NOW) begin
          cnt_next = 32'h0000_0000;
          st_next = ST_PD_FULL;
        end else if (cnt_conv_end) begin
          cnt_next = 32'h0000_0000;
          done_next = 1'b1;
          case (mode_next)
            PM_FULL_AFTER: st_next = ST_PD_FULL;
            PM_PART_AFTER: st_next = ST_PD_PART;
            default: st_next = ST_IDLE;
          endcase
        end
      end
      ST_PD_FULL, ST_PD_PART: begin
        cnt_next = 32'h0000_0000;
        if (mode_next == PM_FULL_NOW || !sleep_lvl) begin
          st_next = ST_PD_FULL;
        end else if (mode_next == PM_NORMAL) begin
          st_next = ST_IDLE;
        end else if (wake_ok) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_INIT;
        cnt_next = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_INIT;
      cnt_reg <= 32'h0000_0000;
      skip_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      skip_reg <= skip_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= PM_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      ref_on_o <= 1'b1;
      core_on_o <= 1'b1;
      conv_done_o <= 1'b0;
      cal_done_o <= 1'b0;
    end else begin
      busy_reg <= (st_next == ST_TMO) || (st_next == ST_CAL) || (st_next == ST_CONV);
      ref_on_o <= (st_next != ST_PD_FULL);
      core_on_o <= (st_next != ST_PD_FULL) && (st_next != ST_PD_PART);
      conv_done_o <= done_next;
      cal_done_o <= cal_next;
    end
  end
  assign link.busy = busy_reg;
  assign mode_o = mode_reg;
endmodule : apm_dev_end
`default_nettype wire

// ==== hw/apm_host_end.sv ====
`default_nettype none
module apm_host_end import apm_pkg::*; #(
  parameter int unsigned IDLE_CYC = IDLE_CYC_DEF,
  parameter int unsigned PU_FULL_CYC = PU_FULL_CYC_DEF,
  parameter int unsigned PU_PART_CYC = PU_PART_CYC_DEF
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [3:0] wb_sel_i, // Byte lanes
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  apm_link_if.host link // Link to device
);
  if (IDLE_CYC < 1 || PU_FULL_CYC < 1 || PU_PART_CYC < 1) begin : g_chk
    $error("apm_host_end: cycle counts must be at least one");
  end

  logic ack_reg;
  logic [31:0] dat_reg;
  logic wr_stb_reg;
  logic [WD_W-1:0] wr_data_reg;
  logic [1:0] ctrl_reg;
  logic [1:0] mode_reg;
  logic trig_n_reg;
  logic [31:0] trig_cnt_reg;
  logic first_reg;
  logic settled_reg;
  logic [31:0] settle_cnt_reg;
  logic busy_lvl;
  logic req;
  logic wr_en;
  logic [31:0] hold_cyc;

  apm_sync3 #(.INIT(1'b0)) u_busy (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(link.busy),
    .lvl_o(busy_lvl),
    .fall_o(),
    .rise_o()
  );

  // ==========================================================
  // Wishbone slave
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_en = req && wb_we_i && ack_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req && !ack_reg;
      if (req && !ack_reg) begin
        case (wb_adr_i)
          ADDR_WDATA: dat_reg <= {20'h0_0000, wr_data_reg};
          ADDR_CTRL: dat_reg <= {30'h0000_0000, ctrl_reg};
          ADDR_STAT: dat_reg <= {28'h000_0000, busy_lvl, !trig_n_reg, settled_reg, first_reg};
          default: dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ==========================================================
  // Control word writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_stb_reg <= 1'b0;
      wr_data_reg <= 12'h000;
      mode_reg <= 2'h0;
      ctrl_reg <= CTRL_RST;
    end else begin
      wr_stb_reg <= 1'b0;
      if (wr_en && wb_adr_i == ADDR_WDATA && wb_sel_i[1:0] == 2'b11) begin
        wr_stb_reg <= 1'b1;
        wr_data_reg <= wb_dat_i[WD_W-1:0];
        // Track mode only on real writes
        if (wb_dat_i[WD_TGT_HI:WD_TGT_LO] != 2'b00) begin
          mode_reg <= wb_dat_i[WD_PSEL_HI:WD_PSEL_LO];
        end
      end
      if (wr_en && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
        ctrl_reg <= wb_dat_i[1:0];
      end
    end
  end

  // ==========================================================
  // Trigger pulse
  // Delay by power-down depth; short one with external reference
  assign hold_cyc = (ctrl_reg[CTRL_EXT_REF] || mode_reg == PM_PART_AFTER) ?
                    32'(PU_PART_CYC) : 32'(PU_FULL_CYC);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_n_reg <= 1'b1;
      trig_cnt_reg <= 32'h0000_0000;
    end else if (!trig_n_reg) begin
      if (trig_cnt_reg == 32'h0000_0000) begin
        trig_n_reg <= 1'b1;
      end else begin
        trig_cnt_reg <= trig_cnt_reg - 32'h0000_0001;
      end
    end else if (wr_en && wb_adr_i == ADDR_TRIG && wb_sel_i[0] && wb_dat_i[0]) begin
      trig_n_reg <= 1'b0;
      trig_cnt_reg <= hold_cyc - 32'h0000_0001;
    end
  end

  // ==========================================================
  // Start-up idle period
  // Settled after seventy ms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_reg <= 1'b0;
      settled_reg <= 1'b0;
      settle_cnt_reg <= 32'h0000_0000;
    end else begin
      if (!trig_n_reg) begin
        first_reg <= 1'b1;
      end
      if (first_reg && !settled_reg) begin
        if (settle_cnt_reg == 32'(IDLE_CYC - 1)) begin
          settled_reg <= 1'b1;
        end else begin
          settle_cnt_reg <= settle_cnt_reg + 32'h0000_0001;
        end
      end
    end
  end

  assign link.wr_stb = wr_stb_reg;
  assign link.wr_data = wr_data_reg;
  assign link.trig_n = trig_n_reg;
  assign link.sleep_n = ctrl_reg[CTRL_SLEEP_N];
endmodule : apm_host_end
`default_nettype wire

// ==== verif/apm_props.sv ====
`default_nettype none
module apm_props import apm_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic wr_stb_i, // Word strobe
  input wire logic [WD_W-1:0] wr_data_i, // Control word
  input wire logic trig_n_i, // Trigger pin
  input wire logic sleep_n_i, // Sleep pin
  input wire logic busy_i, // Busy flag
  input wire logic ref_on_i, // Reference on
  input wire logic core_on_i, // Core on
  input wire logic conv_done_i, // Done pulse
  input wire logic [1:0] mode_i // Select bits
);
  // ==========================================
  // Shared sequences
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence real_wr;
    wr_stb_i && wr_data_i[11:10] != 2'h0;
  endsequence
  sequence conv_end(logic [1:0] m);
    conv_done_i && mode_i == m && sleep_n_i;
  endsequence
  // ==========================================
  // Power mode checks
  a_mode_reset_zero: assert property ($fell(rst_i) |-> mode_i == 2'h0)
    else $error("mode not normal after reset");
  a_mode_stored: assert property (
    real_wr |=> mode_i == 2'($past(wr_data_i) >> 8))
    else $error("select bits not stored");
  a_dummy_keeps_mode: assert property (
    wr_stb_i && wr_data_i[11:10] == 2'h0 |=> $stable(mode_i))
    else $error("discarded word changed mode");
  a_full_now_off: assert property (
    real_wr ##0 wr_data_i[9:8] == 2'h2 |=> !core_on_i && !ref_on_i)
    else $error("immediate power-down missing");
  a_zero_wakes: assert property (
    real_wr ##0 (wr_data_i[9:8] == 2'h0 && sleep_n_i && $past(sleep_n_i, 8))
    |=> core_on_i && ref_on_i)
    else $error("zero select did not wake");
  a_full_after: assert property (conv_end(2'h1) |=> !core_on_i && !ref_on_i)
    else $error("no full power-down after conversion");
  a_part_after: assert property (conv_end(2'h3) |=> !core_on_i && ref_on_i)
    else $error("no partial power-down after conversion");
  a_normal_stays_on: assert property (conv_end(2'h0) |=> core_on_i)
    else $error("normal mode powered down");
  a_trig_wakes: assert property (
    $fell(trig_n_i) && !core_on_i && mode_i[0] && sleep_n_i |-> ##[2:10] core_on_i)
    else $error("trigger did not wake");
  a_busy_powered: assert property (busy_i |-> core_on_i && ref_on_i)
    else $error("powered down while busy");
endmodule : apm_props
`default_nettype wire

// ==== verif/adc_power_management_tb.sv ====
`default_nettype none
module adc_power_management_tb import apm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("BAD %s exp %h got %h", n, e, g); \
    end \
  end
  // ==========================================
  // Signals and instances
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic ack;
  logic ref_on;
  logic core_on;
  logic conv_done;
  logic [1:0] mode;
  int mismatches = 0;
  int check_count = 0;
  int dn = 0;
  int done_cnt = 0;
  int cal_cnt = 0;
  int low_cnt = 0;
  int low_len = 0;
  logic cal_done;
  localparam int unsigned IDLE_N = 50;
  localparam int unsigned PU_FULL_N = 30;
  localparam int unsigned PU_PART_N = 10;
  localparam int unsigned CAL_N = 20;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (conv_done) begin
      done_cnt++;
    end
    if (cal_done) begin
      cal_cnt++;
    end
  end
  apm_link_if apm_link_if_i ();
  apm_host_end #(
    .IDLE_CYC(IDLE_N), .PU_FULL_CYC(PU_FULL_N), .PU_PART_CYC(PU_PART_N)
  ) apm_host_end_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .link(apm_link_if_i));
  apm_dev_end #(.CALTO_CYC(CAL_N), .CAL_CYC(CAL_N), .CONV_CYC(CONV_CYC_DEF)) apm_dev_end_i (
    .clk_i(clk_i), .rst_i(rst_i), .link(apm_link_if_i), .ref_on_o(ref_on),
    .core_on_o(core_on), .conv_done_o(conv_done), .cal_done_o(cal_done), .mode_o(mode));
  apm_props apm_props_i (
    .clk_i(clk_i), .rst_i(rst_i), .wr_stb_i(apm_link_if_i.wr_stb),
    .wr_data_i(apm_link_if_i.wr_data), .trig_n_i(apm_link_if_i.trig_n),
    .sleep_n_i(apm_link_if_i.sleep_n), .busy_i(apm_link_if_i.busy), .ref_on_i(ref_on),
    .core_on_i(core_on), .conv_done_i(conv_done), .mode_i(mode));
  // Length of each trigger-low pulse
  always @(posedge clk_i) begin
    if (apm_link_if_i.trig_n === 1'b0) begin
      low_cnt++;
    end else if (low_cnt > 0) begin
      low_len = low_cnt;
      low_cnt = 0;
    end
  end
  // ==========================================
  // Bus and sequence tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic wait_bit(input int b, input logic v);
    for (int i = 0; i < 200; i++) begin
      rd(ADDR_STAT);
      if (rdat[b] === v) return;
    end
    mismatches++;
    tally_and_finish();
  endtask : wait_bit
  task automatic trig_run();
    wr(ADDR_TRIG, 32'h0000_0001);
    wait_bit(3, 1'b1);
    `CHK("core_busy", 1'b1, core_on)
    wait_bit(3, 1'b0);
    wait_bit(2, 1'b0);
  endtask : trig_run
  task automatic conv_bit(input logic [31:0] w);
    wr(ADDR_WDATA, w);
    wait_bit(3, 1'b1);
    wait_bit(3, 1'b0);
  endtask : conv_bit
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  // ==========================================
  // Tests
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_CTRL);
    `CHK("ctrl", 32'h0000_0001, rdat)
    rd(ADDR_STAT);
    `CHK("stat", 32'h0000_0000, rdat)
    rd(8'h10);
    `CHK("unmapped", 32'h0000_0000, rdat)
    `CHK("mode", 2'h0, mode)
    `CHK("ref", 1'b1, ref_on)
    fin("reset");
    wr(ADDR_CTRL, 32'h0000_0000);
    trig_run();
    `CHK("tmo_low", PU_FULL_N, low_len)
    rd(ADDR_STAT);
    `CHK("first", 1'b1, rdat[0])
    `CHK("not_settled", 1'b0, rdat[1])
    `CHK("no_cal_yet", 0, cal_cnt)
    trig_run();
    `CHK("cal_once", 1, cal_cnt)
    `CHK("asleep", 1'b0, core_on)
    wr(ADDR_CTRL, 32'h0000_0001);
    rd(ADDR_STAT);
    `CHK("settled", 1'b1, rdat[1])
    wr(ADDR_WDATA, 32'h0000_0400);
    `CHK("wake", 1'b1, core_on)
    fin("calibrate");
    trig_run();
    dn++;
    `CHK("pin_conv", dn, done_cnt)
    conv_bit(32'h0000_0401);
    dn++;
    `CHK("bit_conv", dn, done_cnt)
    `CHK("normal_on", 1'b1, core_on)
    fin("convert");
    for (int m = 1; m <= 3; m += 2) begin
      wr(ADDR_WDATA, 32'h0000_0400);
      conv_bit(32'h0000_0401 | (m << 8));
      dn++;
      `CHK("mode", m[1:0], mode)
      `CHK("core_down", 1'b0, core_on)
      `CHK("ref_kept", m == 3, ref_on)
      trig_run();
      dn++;
      `CHK("woke_conv", dn, done_cnt)
      `CHK("wake_low", (m == 3) ? PU_PART_N : PU_FULL_N, low_len)
      `CHK("down_again", 1'b0, core_on)
    end
    fin("powerdown");
    wr(ADDR_WDATA, 32'h0000_03FF);
    `CHK("dummy_mode", 2'h3, mode)
    `CHK("dummy_down", 1'b0, core_on)
    rd(ADDR_WDATA);
    `CHK("wdata", 32'h0000_03FF, rdat)
    wr(ADDR_WDATA, 32'h0000_0400);
    `CHK("zero_wake", 1'b1, core_on)
    `CHK("zero_mode", 2'h0, mode)
    fin("dummy");
    wr(ADDR_CTRL, 32'h0000_0003);
    trig_run();
    dn++;
    `CHK("ext_low", PU_PART_N, low_len)
    `CHK("ext_conv", dn, done_cnt)
    wr(ADDR_CTRL, 32'h0000_0001);
    fin("extref");
    wr(ADDR_WDATA, 32'h0000_0401);
    wr(ADDR_WDATA, 32'h0000_0600);
    `CHK("abort_core", 1'b0, core_on)
    `CHK("abort_ref", 1'b0, ref_on)
    `CHK("abort_busy", 1'b0, apm_link_if_i.busy)
    repeat (CONV_CYC_DEF + 4) @(posedge clk_i);
    `CHK("no_done", dn, done_cnt)
    fin("abort");
    tally_and_finish();
  end
endmodule : adc_power_management_tb
`default_nettype wire
